// [rtl/plsr_regs.sv]
/*
  limit and sequencing command bank: input overvoltage limit, turn-on delay,
  turn-on rise time, and the over-temperature warning threshold decode.
  assumes a protocol engine on the same clock presents decoded word commands,
  and that comparator and strap inputs arrive asynchronously from pins.
*/
`timescale 1ns/1ps

// Operation
// - warn mantissa 26..63 maps to 105..130 degrees by range table
// - input overvoltage limit is command 55h, word read and write
// - input overvoltage fault always latches off switching, no retry
// - overvoltage fault sets input flag and asserts the host alert line
// - overvoltage word: exponent 00001b read-only, bits 10:4 zero, mantissa 3:0
// - mantissa below 9 selects 16.5 V, 9 to 15 selects 18.5 V
// - any written mantissa value is stored and read back unchanged
// - hardware uses the supported setting whose range holds the stored mantissa
// - nvm reload restores one fixed mantissa per supported setting
// - write changing read-only bits is nacked, dropped, sets cml and ivd
// - turn-on delay is command 60h, start request to rise begin
// - delay exponent 11111b, bits 10:3 zero, mantissa 2:0, code 0 gives 50 us
// - delay codes: 0 is 0.05 ms, 1 0.5, 2 1, 3..7 2 ms
// - turn-on rise is command 61h, sets soft-start slew
// - rise exponent 11111b, bits 10:6 zero, mantissa 5:0 reset zero
// - rise codes: <2 0.5, 2..3 1, 4..7 2, 8..15 4, 16..31 8 ms
// - initial rise setting comes from nvm or pin strap
module plsr_regs
#(
  parameter int TIMER_W = 17
)
(
  input  wire logic                clk,
  input  wire logic                sys_rst,
  input  wire plsr_pkg::plsr_req_t req,
  output plsr_pkg::plsr_rsp_t      rsp,
  input  wire logic                nvm_load,
  input  wire logic                nvm_use_strap,
  input  wire logic [5:0]          strap_rise_code,
  input  wire logic                ov_compare_raw,
  input  wire logic                start_request,
  input  wire logic                fault_clear,
  input  wire logic                cml_clear,
  output logic                     switching_enable,
  output logic                     rise_start,
  output plsr_pkg::plsr_ov_sel_t   ov_threshold_sel,
  output plsr_pkg::plsr_rise_sel_t rise_time_sel,
  output plsr_pkg::plsr_otw_sel_t  otw_threshold_sel,
  output logic                     input_overvoltage_flag,
  output logic                     host_alert_line_n,
  output logic                     status_cml,
  output logic [7:0]               comm_status
);
  import plsr_pkg::*;

  // ==========================================================================
  // decode helpers
  function automatic plsr_ov_sel_t ov_sel(input logic [3:0] m);
    ov_sel = (m < OV_HIGH_FROM) ? OV_SEL_16V5 : OV_SEL_18V5;
  endfunction

  function automatic logic [TIMER_W-1:0] delay_cyc(input logic [2:0] m);
    logic [TIMER_W-1:0] step;
    step = TIMER_W'(DELAY_STEP_CYC);
    unique case (m)
      3'd0:    delay_cyc = TIMER_W'(DELAY_MIN_CYC);
      3'd1:    delay_cyc = step;
      3'd2:    delay_cyc = TIMER_W'(2 * DELAY_STEP_CYC);
      default: delay_cyc = TIMER_W'(4 * DELAY_STEP_CYC);
    endcase
  endfunction

  // delay restore codes, one per supported delay setting
  function automatic logic [2:0] dly_restore(input logic [2:0] m);
    unique case (m)
      3'd0:    dly_restore = 3'd0;
      3'd1:    dly_restore = 3'd1;
      3'd2:    dly_restore = 3'd2;
      default: dly_restore = 3'd3;
    endcase
  endfunction

  function automatic plsr_rise_sel_t rise_sel(input logic [5:0] m);
    if (m < 6'd2)       rise_sel = RISE_0MS5;
    else if (m < 6'd4)  rise_sel = RISE_1MS;
    else if (m < 6'd8)  rise_sel = RISE_2MS;
    else if (m < 6'd16) rise_sel = RISE_4MS;
    else if (m < 6'd32) rise_sel = RISE_8MS;
    else                rise_sel = RISE_16MS;
  endfunction

  function automatic logic [5:0] rise_restore(input logic [5:0] m);
    unique case (rise_sel(m))
      RISE_0MS5: rise_restore = 6'd0;
      RISE_1MS:  rise_restore = 6'd2;
      RISE_2MS:  rise_restore = 6'd4;
      RISE_4MS:  rise_restore = 6'd8;
      RISE_8MS:  rise_restore = 6'd16;
      default:   rise_restore = 6'd32;
    endcase
  endfunction

  function automatic plsr_otw_sel_t otw_sel(input logic [5:0] m);
    if (m < 6'd25)      otw_sel = OTW_95;
    else if (m < 6'd26) otw_sel = OTW_100;
    else if (m < 6'd27) otw_sel = OTW_105;
    else if (m < 6'd29) otw_sel = OTW_110;
    else if (m < 6'd30) otw_sel = OTW_115;
    else if (m < 6'd31) otw_sel = OTW_120;
    else if (m < 6'd32) otw_sel = OTW_125;
    else                otw_sel = OTW_130;
  endfunction

  // ==========================================================================
  // stored mantissas, nvm images and write checks
  logic [OV_MANT_W-1:0]   ov_mant;
  logic [DLY_MANT_W-1:0]  dly_mant;
  logic [RISE_MANT_W-1:0] rise_mant;
  logic [OTW_MANT_W-1:0]  otw_mant;
  logic [OV_MANT_W-1:0]   ov_nvm;
  logic [RISE_MANT_W-1:0] rise_nvm;
  logic [DLY_MANT_W-1:0]  dly_nvm;
  logic                   wr_ov;
  logic                   wr_dly;
  logic                   wr_rise;
  logic                   wr_otw;
  logic                   ro_bad;
  logic                   wr_known;

  assign wr_ov    = req.wr && (req.cmd == CMD_INPUT_OV_LIMIT);
  assign wr_dly   = req.wr && (req.cmd == CMD_TURN_ON_DELAY);
  assign wr_rise  = req.wr && (req.cmd == CMD_TURN_ON_RISE);
  assign wr_otw   = req.wr && (req.cmd == CMD_OT_WARN_LIMIT);
  assign wr_known = wr_ov || wr_dly || wr_rise || wr_otw;

  // read-only bits must match what a read would return
  always_comb
  begin
    ro_bad = 1'b0;
    unique case (1'b1)
      wr_ov:   ro_bad = req.wdata[15:OV_MANT_W] != {OV_EXPONENT, 7'h00};
      wr_dly:  ro_bad = req.wdata[15:DLY_MANT_W] != {TIME_EXPONENT, 8'h00};
      wr_rise: ro_bad = req.wdata[15:RISE_MANT_W] != {TIME_EXPONENT, 5'h00};
      wr_otw:  ro_bad = req.wdata[15:OTW_MANT_W] != {OTW_EXPONENT, 5'h00};
      default: ro_bad = 1'b0;
    endcase
  end

  // nvm images track accepted writes as if stored; a store command is outside
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ov_nvm   <= OV_MANT_NVM_DEFAULT;
      rise_nvm <= RISE_MANT_RESET;
      dly_nvm  <= DLY_MANT_RESET;
    end
    else
    begin
      if (wr_ov && !ro_bad)
        ov_nvm <= req.wdata[OV_MANT_W-1:0];
      if (wr_rise && !ro_bad)
        rise_nvm <= req.wdata[RISE_MANT_W-1:0];
      if (wr_dly && !ro_bad)
        dly_nvm <= req.wdata[DLY_MANT_W-1:0];
    end
  end

  // ==========================================================================
  // strap code comes from pins, so two flops guard the reload path; the
  // straps are static after power-up, which is why a plain bus sync is safe
  logic [5:0] strap_sync1;
  logic [5:0] strap_sync2;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      strap_sync1 <= 6'h00;
      strap_sync2 <= 6'h00;
    end
    else
    begin
      strap_sync1 <= strap_rise_code;
      strap_sync2 <= strap_sync1;
    end
  end

  // ==========================================================================
  // mantissa registers: writes take effect on the next edge
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ov_mant   <= OV_MANT_NVM_DEFAULT;
      dly_mant  <= DLY_MANT_RESET;
      rise_mant <= RISE_MANT_RESET;
      otw_mant  <= OTW_MANT_NVM_DEFAULT;
    end
    else if (nvm_load)
    begin
      ov_mant  <= (ov_sel(ov_nvm) == OV_SEL_16V5) ? OV_RESTORE_LOW : OV_RESTORE_HIGH;
      dly_mant <= dly_restore(dly_nvm);
      rise_mant <= nvm_use_strap ? rise_restore(strap_sync2)
                                 : rise_restore(rise_nvm);
    end
    else if (wr_known && !ro_bad)
    begin
      if (wr_ov)
        ov_mant <= req.wdata[OV_MANT_W-1:0];
      if (wr_dly)
        dly_mant <= req.wdata[DLY_MANT_W-1:0];
      if (wr_rise)
        rise_mant <= req.wdata[RISE_MANT_W-1:0];
      if (wr_otw)
        otw_mant <= req.wdata[OTW_MANT_W-1:0];
    end
  end

  // ==========================================================================
  // command response: one cycle after the request
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rsp <= '0;
    end
    else
    begin
      rsp.valid <= req.wr || req.rd;
      rsp.nack  <= req.wr && (ro_bad || !wr_known);
      rsp.rdata <= 16'h0000;
      if (req.rd)
      begin
        unique case (req.cmd)
          CMD_INPUT_OV_LIMIT: rsp.rdata <= {OV_EXPONENT, 7'h00, ov_mant};
          CMD_TURN_ON_DELAY:  rsp.rdata <= {TIME_EXPONENT, 8'h00, dly_mant};
          CMD_TURN_ON_RISE:   rsp.rdata <= {TIME_EXPONENT, 5'h00, rise_mant};
          CMD_OT_WARN_LIMIT:  rsp.rdata <= {OTW_EXPONENT, 5'h00, otw_mant};
          CMD_COMM_STATUS:    rsp.rdata <= {8'h00, comm_status};
          default:            rsp.rdata <= 16'h0000;
        endcase
      end
    end
  end

  // ==========================================================================
  // command error flags; a new error beats a clear in the same cycle
  // unknown-command writes are nacked by the response path but leave these alone
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      status_cml  <= 1'b0;
      comm_status <= 8'h00;
    end
    else if (wr_known && ro_bad)
    begin
      status_cml               <= 1'b1;
      comm_status[CML_IVD_BIT] <= 1'b1;
    end
    else if (cml_clear)
    begin
      status_cml  <= 1'b0;
      comm_status <= 8'h00;
    end
  end

  // ==========================================================================
  // comparator input crosses in through two flops
  logic ov_sync1;
  logic ov_sync2;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ov_sync1 <= 1'b0;
      ov_sync2 <= 1'b0;
    end
    else
    begin
      ov_sync1 <= ov_compare_raw;
      ov_sync2 <= ov_sync1;
    end
  end

  // latch-off: only an explicit clear restarts, never a timer
  // a comparator still high re-asserts the latch, so a clear cannot mask it
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      input_overvoltage_flag <= 1'b0;
      switching_enable       <= 1'b1;
      host_alert_line_n      <= 1'b1;
    end
    else if (ov_sync2)
    begin
      input_overvoltage_flag <= 1'b1;
      switching_enable       <= 1'b0;
      host_alert_line_n      <= 1'b0;
    end
    else if (fault_clear)
    begin
      input_overvoltage_flag <= 1'b0;
      switching_enable       <= 1'b1;
      host_alert_line_n      <= 1'b1;
    end
  end

  // ==========================================================================
  // turn-on delay; start request is same-clock logic
  logic timer_done;

  plsr_delay_timer #(
    .CNT_W (TIMER_W)
  ) u_delay (
    .clk         (clk),
    .sys_rst     (sys_rst),
    .start       (start_request && switching_enable),
    .abort       (ov_sync2),
    .load_cycles (delay_cyc(dly_mant)),
    .busy        (),
    .done        (timer_done)
  );

  // registered decoded settings; reg updates apply on the fly
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rise_start        <= 1'b0;
      ov_threshold_sel  <= OV_SEL_18V5;
      rise_time_sel     <= RISE_0MS5;
      otw_threshold_sel <= OTW_125;
    end
    else
    begin
      rise_start        <= timer_done && switching_enable;
      ov_threshold_sel  <= ov_sel(ov_mant);
      rise_time_sel     <= rise_sel(rise_mant);
      otw_threshold_sel <= otw_sel(otw_mant);
    end
  end

endmodule

// [rtl/plsr_pkg.sv]
/*
  shared constants and carriers for the limit and sequencing command bank.
  assumes a single 25 MHz clock and a command-level word access port.
*/
package plsr_pkg;

  // ==========================================================================
  // command codes
  localparam logic [7:0] CMD_INPUT_OV_LIMIT = 8'h55;
  localparam logic [7:0] CMD_TURN_ON_DELAY  = 8'h60;
  localparam logic [7:0] CMD_TURN_ON_RISE   = 8'h61;
  localparam logic [7:0] CMD_COMM_STATUS    = 8'h7e;
  localparam logic [7:0] CMD_OT_WARN_LIMIT  = 8'h51;

  // ==========================================================================
  // word layouts
  localparam logic [4:0] OV_EXPONENT   = 5'h01;
  localparam logic [4:0] TIME_EXPONENT = 5'h1f;
  localparam logic [4:0] OTW_EXPONENT  = 5'h02;
  localparam int         EXP_LSB       = 11;
  localparam int         OV_MANT_W     = 4;
  localparam int         DLY_MANT_W    = 3;
  localparam int         RISE_MANT_W   = 6;
  localparam int         OTW_MANT_W    = 6;
  localparam int         CML_IVD_BIT   = 6;

  // ==========================================================================
  // reset and nonvolatile defaults
  localparam logic [3:0] OV_MANT_NVM_DEFAULT  = 4'h9;
  localparam logic [2:0] DLY_MANT_RESET       = 3'h0;
  localparam logic [5:0] RISE_MANT_RESET      = 6'h00;
  localparam logic [5:0] OTW_MANT_NVM_DEFAULT = 6'h22;

  // ==========================================================================
  // quantisation thresholds and restore codes
  localparam logic [3:0] OV_HIGH_FROM    = 4'h9;
  localparam logic [3:0] OV_RESTORE_LOW  = 4'h0;
  localparam logic [3:0] OV_RESTORE_HIGH = 4'h9;

  // ==========================================================================
  // timing: clock rate and turn-on delay figures
  localparam int CLK_HZ          = 25_000_000;
  localparam int DELAY_MIN_NS    = 50_000;
  localparam int DELAY_STEP_NS   = 500_000;
  localparam int DELAY_MIN_CYC   = (DELAY_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int DELAY_STEP_CYC  = DELAY_STEP_NS * (CLK_HZ / 1_000_000) / 1000;

  // ==========================================================================
  // selection encodings
  typedef enum logic [1:0] {OV_SEL_16V5, OV_SEL_18V5} plsr_ov_sel_t;
  typedef enum logic [2:0] {RISE_0MS5, RISE_1MS, RISE_2MS, RISE_4MS, RISE_8MS, RISE_16MS}
    plsr_rise_sel_t;
  typedef enum logic [2:0] {OTW_95, OTW_100, OTW_105, OTW_110, OTW_115, OTW_120, OTW_125,
    OTW_130} plsr_otw_sel_t;

  // command port carriers
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  cmd;
    logic [15:0] wdata;
  } plsr_req_t;

  typedef struct packed {
    logic        valid;
    logic        nack;
    logic [15:0] rdata;
  } plsr_rsp_t;

endpackage

// [rtl/plsr_delay_timer.sv]
/*
  turn-on delay timer: counts from a start request to the release of the rise.
  assumes start is a one-cycle pulse from logic on the same clock.
*/
`timescale 1ns/1ps
module plsr_delay_timer
#(
  parameter int CNT_W = 17
)
(
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             start,
  input  wire logic             abort,
  input  wire logic [CNT_W-1:0] load_cycles,
  output logic                  busy,
  output logic                  done
);
  import plsr_pkg::*;

  logic [CNT_W-1:0] count;

  // ==========================================================================
  // down counter; abort wins so a fault never lets the rise begin
  always_ff @(posedge clk)
  begin
    if (sys_rst || abort)
    begin
      count <= '0;
      busy  <= 1'b0;
      done  <= 1'b0;
    end
    else if (start)
    begin
      count <= load_cycles;
      busy  <= 1'b1;
      done  <= 1'b0;
    end
    else if (busy)
    begin
      count <= count - CNT_W'(1);
      done  <= (count == CNT_W'(1));
      busy  <= (count != CNT_W'(1));
    end
    else
    begin
      done <= 1'b0;
    end
  end

endmodule

// [verif/plsr_regs_asserts.sv]
/*
  port checker for the limit and sequencing command bank.
  assumes it is bound onto plsr_regs, one clock, synchronous reset.
*/
`timescale 1ns/1ps
module plsr_regs_asserts
(
  input wire logic                   clk,
  input wire logic                   sys_rst,
  input wire plsr_pkg::plsr_req_t    req,
  input wire plsr_pkg::plsr_rsp_t    rsp,
  input wire logic                   nvm_load,
  input wire logic                   ov_compare_raw,
  input wire logic                   fault_clear,
  input wire logic                   switching_enable,
  input wire plsr_pkg::plsr_ov_sel_t ov_threshold_sel,
  input wire logic                   input_overvoltage_flag,
  input wire logic                   host_alert_line_n,
  input wire logic                   status_cml,
  input wire logic [7:0]             comm_status
);
  import plsr_pkg::*;
  // ==========================================================================
  // handshake and word layout
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // refusal: nack now, error flags one edge later
  sequence s_refused;
    rsp.valid && rsp.nack ##1 status_cml && comm_status[CML_IVD_BIT];
  endsequence
  property p_answer;
    (req.wr || req.rd) && !nvm_load |=> rsp.valid;
  endproperty
  a_answer: assert property (p_answer) else $error("request not answered");
  property p_quiet;
    !(req.wr || req.rd) |=> !rsp.valid;
  endproperty
  a_quiet: assert property (p_quiet) else $error("answer without request");
  property p_refuse;
    req.wr && !nvm_load && req.cmd == CMD_TURN_ON_DELAY && req.wdata[15:3] != 13'h1f00
      |=> s_refused;
  endproperty
  a_refuse: assert property (p_refuse) else $error("bad write not refused");
  property p_dly_rd;
    req.rd && req.cmd == CMD_TURN_ON_DELAY |=> rsp.rdata[15:3] == 13'h1f00;
  endproperty
  a_dly_rd: assert property (p_dly_rd) else $error("delay word fixed bits");
  property p_rise_rd;
    req.rd && req.cmd == CMD_TURN_ON_RISE |=> rsp.rdata[15:6] == 10'h3e0;
  endproperty
  a_rise_rd: assert property (p_rise_rd) else $error("rise word fixed bits");
  property p_ov_rd;
    req.rd && req.cmd == CMD_INPUT_OV_LIMIT |=> rsp.rdata[15:4] == 12'h080;
  endproperty
  a_ov_rd: assert property (p_ov_rd) else $error("limit word fixed bits");
  // ==========================================================================
  // threshold decode and latch-off
  property p_ov_sel;
    req.wr && !nvm_load && req.cmd == CMD_INPUT_OV_LIMIT && req.wdata[15:4] == 12'h080
      |=> ##1 ov_threshold_sel == ($past(req.wdata[3:0], 2) >= 4'h9 ? OV_SEL_18V5 : OV_SEL_16V5);
  endproperty
  a_ov_sel: assert property (p_ov_sel) else $error("limit select wrong");
  property p_trip;
    ov_compare_raw [*3] |=> !switching_enable && input_overvoltage_flag && !host_alert_line_n;
  endproperty
  a_trip: assert property (p_trip) else $error("no latch-off on fault");
  // no retry: only a clear may lift the latch
  property p_latched;
    !switching_enable && !fault_clear && !$past(fault_clear) |=> !switching_enable;
  endproperty
  a_latched: assert property (p_latched) else $error("latch-off lifted");
endmodule

bind plsr_regs plsr_regs_asserts i_plsr_regs_asserts (.clk, .sys_rst, .req, .rsp, .nvm_load,
  .ov_compare_raw, .fault_clear, .switching_enable, .ov_threshold_sel,
  .input_overvoltage_flag, .host_alert_line_n, .status_cml, .comm_status);

// [verif/plsr_host.sv]
/*
  host model issuing whole word reads and writes on the command port.
  assumes the bank answers one edge after each request.
*/
`timescale 1ns/1ps
module plsr_host
(
  input  wire logic          clk,
  output plsr_pkg::plsr_req_t req
);
  import plsr_pkg::*;
  initial req = '0;
  // ==========================================================================
  // one transfer, held a whole cycle from a falling edge
  task automatic xfer(input logic wr, input logic [7:0] cmd, input logic [15:0] d);
    @(negedge clk);
    req <= '{wr, !wr, cmd, d};
    @(negedge clk);
    req <= '0;
  endtask
endmodule

// [verif/plsr_regs_tb.sv]
/*
  self-checking bench for the command bank.
  assumes the host model and the bound port checker.
*/
`timescale 1ns/1ps
module plsr_regs_tb;
  import plsr_pkg::*;
  logic             clk, sys_rst, nvm_load, nvm_use_strap, ov_compare_raw;
  logic             start_request, fault_clear, cml_clear, switching_enable, rise_start;
  logic             input_overvoltage_flag, host_alert_line_n, status_cml;
  logic [5:0]       strap_rise_code;
  logic [7:0]       comm_status;
  logic [15:0]      w;
  logic [16:0]      expq [$];
  plsr_req_t        req;
  plsr_rsp_t        rsp;
  plsr_ov_sel_t     ov_threshold_sel;
  plsr_rise_sel_t   rise_time_sel;
  plsr_otw_sel_t    otw_threshold_sel;
  int               fail_count = 0;
  int               checked = 0;
  int               k, n;
  int               seed = 32'h883bf8df;
  localparam logic [7:0] CMDS [4] = '{CMD_INPUT_OV_LIMIT, CMD_TURN_ON_DELAY,
                                      CMD_TURN_ON_RISE, CMD_OT_WARN_LIMIT};

  plsr_host i_plsr_host (.clk, .req);
  plsr_regs i_plsr_regs (.clk, .sys_rst, .req, .rsp, .nvm_load, .nvm_use_strap,
    .strap_rise_code, .ov_compare_raw, .start_request, .fault_clear, .cml_clear,
    .switching_enable, .rise_start, .ov_threshold_sel, .rise_time_sel, .otw_threshold_sel,
    .input_overvoltage_flag, .host_alert_line_n, .status_cml, .comm_status);

  // ==========================================================================
  // clock, compare, bus and closing tasks
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic cmp(input logic [16:0] e, input logic [16:0] g);
    checked++;
    if (g !== e)
    begin
      fail_count++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d, input logic nk);
    expq.push_back({nk, 16'h0000});
    i_plsr_host.xfer(1'b1, c, d);
  endtask
  task automatic rd(input logic [7:0] c, input logic [15:0] e);
    expq.push_back({1'b0, e});
    i_plsr_host.xfer(1'b0, c, 16'h0000);
  endtask
  task automatic end_of_test;
    repeat (4) @(negedge clk);
    $display("checked %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  function automatic logic [2:0] rise_of(input int m);
    rise_of = m < 2 ? 3'h0 : m < 4 ? 3'h1 : m < 8 ? 3'h2 : m < 16 ? 3'h3 : m < 32 ? 3'h4 : 3'h5;
  endfunction
  function automatic logic [2:0] otw_of(input int m);
    otw_of = m < 25 ? 3'h0 : m < 26 ? 3'h1 : m < 27 ? 3'h2 : m < 29 ? 3'h3 :
             m < 30 ? 3'h4 : m < 31 ? 3'h5 : m < 32 ? 3'h6 : 3'h7;
  endfunction
  task automatic nvm(input logic s);
    nvm_use_strap = s;
    nvm_load = 1'b1;
    @(negedge clk);
    nvm_load = 1'b0;
  endtask
  // timer waits are bounded; running out closes the run
  task automatic run_delay(input logic [2:0] c, input int cyc);
    wr(CMD_TURN_ON_DELAY, {13'h1f00, c}, 1'b0);
    repeat (2) @(negedge clk);
    start_request = 1'b1;
    @(negedge clk);
    start_request = 1'b0;
    for (n = 1; n < 60000 && rise_start !== 1'b1; n++)
      @(negedge clk);
    cmp(1'b1, n >= cyc && n <= cyc + 4);
    if (rise_start !== 1'b1)
      end_of_test();
  endtask

  // response watcher: oldest note against each answer
  always @(negedge clk)
    if (rsp.valid === 1'b1)
      cmp(expq.size() > 0 ? expq.pop_front() : 17'hx, {rsp.nack, rsp.rdata});

  // ==========================================================================
  // main sequence
  initial
  begin
    {sys_rst, nvm_load, nvm_use_strap, ov_compare_raw} = 4'h8;
    {start_request, fault_clear, cml_clear} = 3'h0;
    strap_rise_code = 6'h10;
    repeat (20) @(negedge clk);
    sys_rst = 1'b0;
    rd(CMD_INPUT_OV_LIMIT, 16'h0809);
    rd(CMD_TURN_ON_DELAY, 16'hf800);
    rd(CMD_TURN_ON_RISE, 16'hf800);
    $display("reset values done");
    for (k = 0; k < 64; k++)
    begin
      wr(CMD_INPUT_OV_LIMIT, {12'h080, k[3:0]}, 1'b0);
      wr(CMD_TURN_ON_DELAY, {13'h1f00, k[2:0]}, 1'b0);
      wr(CMD_TURN_ON_RISE, {10'h3e0, k[5:0]}, 1'b0);
      wr(CMD_OT_WARN_LIMIT, {10'h040, k[5:0]}, 1'b0);
      rd(CMD_INPUT_OV_LIMIT, {12'h080, k[3:0]});
      rd(CMD_TURN_ON_DELAY, {13'h1f00, k[2:0]});
      rd(CMD_TURN_ON_RISE, {10'h3e0, k[5:0]});
      cmp(k[3:0] >= 4'h9, ov_threshold_sel);
      cmp(rise_of(k), rise_time_sel);
      cmp(otw_of(k), otw_threshold_sel);
    end
    $display("mantissa sweep done");
    for (k = 0; k < 8; k++)
    begin
      w = 16'($random(seed));
      w[10] = 1'b1;
      wr(CMDS[k % 4], w, 1'b1);
      repeat (2) @(negedge clk);
      cmp(2'b11, {status_cml, comm_status[CML_IVD_BIT]});
      rd(CMD_COMM_STATUS, 16'h0040);
      cml_clear = 1'b1;
      @(negedge clk);
      cml_clear = 1'b0;
    end
    rd(CMD_TURN_ON_DELAY, 16'hf807);
    $display("refusal done");
    wr(CMD_INPUT_OV_LIMIT, 16'h0803, 1'b0);
    wr(CMD_TURN_ON_RISE, 16'hf805, 1'b0);
    nvm(1'b0);
    rd(CMD_INPUT_OV_LIMIT, 16'h0800);
    rd(CMD_TURN_ON_DELAY, 16'hf803);
    rd(CMD_TURN_ON_RISE, 16'hf804);
    nvm(1'b1);
    rd(CMD_TURN_ON_RISE, 16'hf810);
    $display("reload done");
    ov_compare_raw = 1'b1;
    repeat (5) @(negedge clk);
    ov_compare_raw = 1'b0;
    cmp(3'b010, {switching_enable, input_overvoltage_flag, host_alert_line_n});
    repeat (20) @(negedge clk);
    cmp(1'b0, switching_enable);
    fault_clear = 1'b1;
    @(negedge clk);
    fault_clear = 1'b0;
    repeat (2) @(negedge clk);
    cmp(1'b1, switching_enable);
    cmp(2'b01, {input_overvoltage_flag, host_alert_line_n});
    $display("latch-off done");
    run_delay(3'h0, DELAY_MIN_CYC);
    run_delay(3'h1, DELAY_STEP_CYC);
    run_delay(3'h5, 4 * DELAY_STEP_CYC);
    $display("turn-on delay done");
    wr(CMD_INPUT_OV_LIMIT, 16'hffff, 1'b1);
    sys_rst = 1'b1;
    repeat (3) @(negedge clk);
    sys_rst = 1'b0;
    wr(8'h00, 16'h0000, 1'b1);
    repeat (2) @(negedge clk);
    cmp(2'b00, {status_cml, comm_status[CML_IVD_BIT]});
    rd(CMD_TURN_ON_DELAY, 16'hf800);
    rd(CMD_INPUT_OV_LIMIT, 16'h0809);
    $display("mid-run reset done");
    end_of_test();
  end
endmodule
